// *** verilog/fcl_pkg.sv ***
// Constants, types and fixed-point helpers for the current loop.
// Assumes a single 100 MHz clock and signed Q1.15 current and voltage words.
package fcl_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CW = 20;
  localparam int CLK_NS = 10;
  localparam int LOOP_NS = 1000;
  localparam int PWM_MIN_NS = 10000;
  localparam int PWM_MAX_NS = 1000000;
  // Least times round up, longest times round down
  localparam logic [CW-1:0] LOOP_CYC = CW'((LOOP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] PWM_MIN_CYC = CW'((PWM_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] PWM_MAX_CYC = CW'(PWM_MAX_NS / CLK_NS);

  // ------------------------------------------------------------
  // Fixed-point constants and bridge enable masks
  // ------------------------------------------------------------
  localparam logic signed [15:0] INV_SQRT3 = 16'sh49E7;
  localparam logic signed [15:0] SQRT3_HALF = 16'sh6EDA;
  localparam logic signed [15:0] QUARTER_TURN = 16'sh4000;
  localparam logic signed [15:0] UNIT_Q15 = 16'sh7FFF;
  localparam logic signed [15:0] ALIGN_STEP = 16'sh0010;
  localparam logic signed [15:0] ZERO16 = 16'sh0000;
  localparam logic [2:0] BRIDGE_ALL = 3'h7;
  localparam logic [2:0] BRIDGE_XY = 3'h3;
  localparam logic [2:0] BRIDGE_FIRST = 3'h1;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    FCL_STOP, FCL_TORQUE, FCL_VELOCITY, FCL_POSITION, FCL_OPEN_LOOP,
    FCL_ALIGN, FCL_PWM_TORQ, FCL_PWM_VEL, FCL_PWM_POS,
    FCL_ANA_TORQ, FCL_ANA_VEL, FCL_ANA_POS
  } fcl_mode_t;

  typedef enum logic [1:0] {
    FCL_THREE_PHASE, FCL_TWO_PHASE, FCL_DC_MOTOR
  } fcl_motor_t;

  // ------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------
  // Saturate a wide signed value to 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh00_0000_7FFF) return 16'sh7FFF;
    if (v < -40'sh00_0000_8000) return 16'sh8000;
    return v[15:0];
  endfunction

  // Symmetric clip to a non-negative limit
  function automatic logic signed [15:0] clip16(input logic signed [15:0] v,
                                                input logic signed [15:0] lim);
    if (v > lim) return lim;
    if (v < -lim) return -lim;
    return v;
  endfunction

  // Q1.15 product with saturation
  function automatic logic signed [15:0] mul_q15(input logic signed [15:0] a,
                                                 input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    return sat16(40'(p >>> 15));
  endfunction

  // Parabolic sine of a half-turn-scaled angle
  function automatic logic signed [15:0] sin_q15(input logic signed [15:0] a);
    logic signed [16:0] ax;
    logic signed [16:0] m;
    logic signed [33:0] p;
    ax = a[15] ? -{a[15], a} : {a[15], a};
    m = 17'sh08000 - ax;
    p = $signed({a[15], a}) * m; // Keep the product signed for negative angles
    return sat16(40'(p >>> 13));
  endfunction

endpackage

// *** verilog/fcl_pi.sv ***
// PI regulator for one current axis.
// Assumes i_en is a one-cycle pulse and i_limit is non-negative.
`timescale 1ns/1ps
module fcl_pi (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_en,
  input wire logic i_hold,
  input wire logic signed [15:0] i_target,
  input wire logic signed [15:0] i_actual,
  input wire logic signed [15:0] i_kp,
  input wire logic signed [15:0] i_ki,
  input wire logic signed [15:0] i_limit,
  output logic signed [15:0] o_out
);

  typedef struct packed {
    logic signed [15:0] integ;
    logic signed [15:0] out;
  } fcl_pi_st_t;

  fcl_pi_st_t r;
  fcl_pi_st_t n;

  // ------------------------------------------------------------
  // Regulator step
  // ------------------------------------------------------------
  always_comb begin
    logic signed [15:0] e;
    logic signed [31:0] pp;
    logic signed [31:0] ip;
    logic signed [15:0] pterm;
    e = fcl_pkg::sat16(40'(i_target) - 40'(i_actual));
    pp = i_kp * e;
    ip = i_ki * e;
    pterm = fcl_pkg::sat16(40'(pp >>> 8)); // Gain is Q8.8
    n = r;
    if (i_hold) begin
      n = '0;
    end else if (i_en) begin
      // Integral gain is Q0.15, integrator clipped to the limit
      n.integ = fcl_pkg::clip16(fcl_pkg::sat16(40'(r.integ) + 40'(ip >>> 15)), i_limit);
      n.out = fcl_pkg::clip16(fcl_pkg::sat16(40'(pterm) + 40'(n.integ)), i_limit);
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_out = r.out;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_pi_out_limit: assert property (i_en && !i_hold |=>
    (o_out <= $past(i_limit)) && (o_out >= -$past(i_limit)))
    else $error("regulator output beyond its limit");
  a_pi_hold_clear: assert property (i_hold |=>
    o_out == 16'sh0000 && r.integ == 16'sh0000)
    else $error("held regulator not cleared");
  a_pi_idle_keep: assert property (!i_en && !i_hold |=> $stable(o_out))
    else $error("regulator output moved without an evaluation");

endmodule // fcl_pi

// *** verilog/fcl_current_loop.sv ***
// Field-oriented current loop with motion-mode and reference selection.
// Assumes phase currents, angle and analog samples arrive on i_ref_clk;
// step, direction and the PWM reference come straight from pins.
`timescale 1ns/1ps
module fcl_current_loop #(
  parameter logic [fcl_pkg::CW-1:0] LOOP_DIV = fcl_pkg::LOOP_CYC,
  parameter logic [fcl_pkg::CW-1:0] PWM_MIN = fcl_pkg::PWM_MIN_CYC,
  parameter logic [fcl_pkg::CW-1:0] PWM_MAX = fcl_pkg::PWM_MAX_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_motor_type,
  input wire logic [3:0] i_motion_mode,
  input wire logic signed [15:0] i_cur_u,
  input wire logic signed [15:0] i_cur_v,
  input wire logic signed [15:0] i_cur_w,
  input wire logic signed [15:0] i_angle,
  input wire logic signed [15:0] i_id_target,
  input wire logic signed [15:0] i_torque_target,
  input wire logic signed [15:0] i_cascade_iq,
  input wire logic signed [15:0] i_vel_target,
  input wire logic signed [31:0] i_pos_target,
  input wire logic signed [15:0] i_kp_flux,
  input wire logic signed [15:0] i_ki_flux,
  input wire logic signed [15:0] i_kp_torque,
  input wire logic signed [15:0] i_ki_torque,
  input wire logic signed [15:0] i_u_limit,
  input wire logic signed [15:0] i_ud_ext,
  input wire logic signed [15:0] i_uq_ext,
  input wire logic signed [15:0] i_align_current,
  input wire logic i_step_dir_en,
  input wire logic i_step_pin,
  input wire logic i_dir_pin,
  input wire logic i_pwm_ref_pin,
  input wire logic i_pwm_check_en,
  input wire logic signed [15:0] i_analog_ref,
  input wire logic i_analog_valid,
  input wire logic signed [15:0] i_ref_offset,
  input wire logic signed [15:0] i_ref_gain,
  output logic signed [15:0] o_u_a,
  output logic signed [15:0] o_u_b,
  output logic signed [15:0] o_u_c,
  output logic [2:0] o_bridge_en,
  output logic o_update,
  output logic signed [15:0] o_id,
  output logic signed [15:0] o_iq,
  output logic signed [15:0] o_vel_target,
  output logic signed [31:0] o_pos_target,
  output logic signed [15:0] o_ref_value,
  output logic o_ref_valid,
  output logic o_ref_freq_err,
  output logic [fcl_pkg::CW-1:0] o_ref_period,
  output logic o_align_active
);

  localparam int CW = fcl_pkg::CW;

  typedef enum logic [1:0] {S_IDLE, S_MEAS, S_REG, S_OUT} fcl_fsm_t;

  typedef struct packed {
    fcl_fsm_t st;
    fcl_pkg::fcl_mode_t mode;
    fcl_pkg::fcl_motor_t motor;
    logic [CW-1:0] div;
    logic [2:0] stp_s;
    logic [2:0] dir_s;
    logic [2:0] pwm_s;
    logic stp_l;
    logic dir_l;
    logic pwm_l;
    logic signed [31:0] step_pos;
    logic [CW-1:0] per_cnt;
    logic [CW-1:0] hi_cnt;
    logic [CW-1:0] per_lat;
    logic [CW-1:0] hi_lat;
    logic seen;
    logic signed [15:0] ref_val;
    logic ref_ok;
    logic freq_err;
    logic signed [15:0] sn;
    logic signed [15:0] cs;
    logic signed [15:0] id;
    logic signed [15:0] iq;
    logic signed [15:0] id_t;
    logic signed [15:0] iq_t;
    logic signed [15:0] align_id;
    logic signed [15:0] ud;
    logic signed [15:0] uq;
    logic signed [15:0] u_a;
    logic signed [15:0] u_b;
    logic signed [15:0] u_c;
    logic [2:0] bridge;
    logic update;
    logic signed [15:0] vel_t;
    logic signed [31:0] pos_t;
    logic align_on;
  } fcl_st_t;

  fcl_st_t r;
  fcl_st_t n;
  logic tick;
  logic step_rise;
  logic pwm_rise;
  logic pi_en;
  logic pi_hold;
  logic signed [15:0] flux_u;
  logic signed [15:0] torq_u;

  // ------------------------------------------------------------
  // Loop rate, pin edges and regulator control
  // ------------------------------------------------------------
  assign tick = (r.div == LOOP_DIV - CW'(1));
  assign step_rise = (r.stp_s[1] == r.stp_s[2]) && r.stp_s[2] && !r.stp_l;
  assign pwm_rise = (r.pwm_s[1] == r.pwm_s[2]) && r.pwm_s[2] && !r.pwm_l;
  assign pi_en = (r.st == S_REG);
  // Regulators run only in closed-loop modes; stop, open loop and unknown codes clear them
  assign pi_hold = !(r.mode inside {[fcl_pkg::FCL_TORQUE:fcl_pkg::FCL_POSITION],
                                    [fcl_pkg::FCL_ALIGN:fcl_pkg::FCL_ANA_POS]});

  // Flux and torque regulators
  fcl_pi u_pi_flux (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(pi_en),
    .i_hold(pi_hold),
    .i_target(r.id_t),
    .i_actual(r.id),
    .i_kp(i_kp_flux),
    .i_ki(i_ki_flux),
    .i_limit(i_u_limit),
    .o_out(flux_u)
  );
  fcl_pi u_pi_torque (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(pi_en),
    .i_hold(pi_hold),
    .i_target(r.iq_t),
    .i_actual(r.iq),
    .i_kp(i_kp_torque),
    .i_ki(i_ki_torque),
    .i_limit(i_u_limit),
    .o_out(torq_u)
  );

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic signed [15:0] ia;
    logic signed [15:0] ib;
    logic signed [15:0] ud;
    logic signed [15:0] uq;
    logic signed [15:0] ua;
    logic signed [15:0] ub;
    logic signed [15:0] raw;
    logic signed [16:0] dif;
    logic signed [33:0] prod;
    logic per_bad;
    logic ana;
    ia = '0;
    ib = '0;
    ud = '0;
    uq = '0;
    ua = '0;
    ub = '0;
    n = r;
    n.update = 1'b0;
    n.div = tick ? '0 : r.div + CW'(1);

    // Three-stage pin sampling, level taken when stages two and three agree
    n.stp_s = {r.stp_s[1:0], i_step_pin};
    n.dir_s = {r.dir_s[1:0], i_dir_pin};
    n.pwm_s = {r.pwm_s[1:0], i_pwm_ref_pin};
    if (r.stp_s[1] == r.stp_s[2]) n.stp_l = r.stp_s[2];
    if (r.dir_s[1] == r.dir_s[2]) n.dir_l = r.dir_s[2];
    if (r.pwm_s[1] == r.pwm_s[2]) n.pwm_l = r.pwm_s[2];

    // Step counter for the position target
    if (step_rise && i_step_dir_en) begin
      n.step_pos = r.dir_l ? r.step_pos - 32'sh0000_0001 : r.step_pos + 32'sh0000_0001;
    end

    // PWM reference period and high time, saturating
    if (r.per_cnt != '1) n.per_cnt = r.per_cnt + CW'(1);
    if (r.pwm_l && r.hi_cnt != '1) n.hi_cnt = r.hi_cnt + CW'(1);
    if (pwm_rise) begin
      n.per_lat = r.per_cnt;
      n.hi_lat = r.hi_cnt;
      n.per_cnt = CW'(1);
      n.hi_cnt = '0;
      n.seen = 1'b1;
    end
    per_bad = !r.seen || (r.per_cnt > PWM_MAX) ||
              (i_pwm_check_en && ((r.per_lat < PWM_MIN) || (r.per_lat > PWM_MAX)));

    // Analog or pin reference source, scaling and status
    ana = r.mode inside {fcl_pkg::FCL_ANA_TORQ, fcl_pkg::FCL_ANA_VEL, fcl_pkg::FCL_ANA_POS};
    raw = ana ? i_analog_ref :
          fcl_pkg::sat16(40'({1'b0, r.hi_lat}) - 40'({2'b00, r.per_lat[CW-1:1]}));
    dif = {raw[15], raw} - {i_ref_offset[15], i_ref_offset};
    prod = dif * i_ref_gain;
    n.ref_val = fcl_pkg::sat16(40'(prod >>> 8));
    n.ref_ok = ana ? i_analog_valid : !per_bad;
    n.freq_err = per_bad;

    case (r.st)
      S_IDLE: begin
        if (tick) begin
          n.mode = fcl_pkg::fcl_mode_t'(i_motion_mode);
          n.motor = fcl_pkg::fcl_motor_t'(i_motor_type);
          n.sn = fcl_pkg::sin_q15(i_angle);
          n.cs = fcl_pkg::sin_q15(i_angle + fcl_pkg::QUARTER_TURN);
          if (n.mode == fcl_pkg::FCL_ALIGN) begin
            n.sn = fcl_pkg::ZERO16; // Field held on the D axis
            n.cs = fcl_pkg::UNIT_Q15;
          end
          n.st = S_MEAS;
        end
      end
      S_MEAS: begin
        // Current transforms
        ia = i_cur_u;
        if (r.motor == fcl_pkg::FCL_THREE_PHASE) begin
          ib = fcl_pkg::mul_q15(fcl_pkg::sat16(40'(i_cur_v) - 40'(i_cur_w)),
                                fcl_pkg::INV_SQRT3);
        end else begin
          ib = i_cur_v;
        end
        if (r.motor == fcl_pkg::FCL_DC_MOTOR) begin
          n.id = fcl_pkg::ZERO16;
          n.iq = i_cur_u;
        end else begin
          n.id = fcl_pkg::sat16(40'(fcl_pkg::mul_q15(ia, r.cs)) +
                                40'(fcl_pkg::mul_q15(ib, r.sn)));
          n.iq = fcl_pkg::sat16(40'(fcl_pkg::mul_q15(ib, r.cs)) -
                                40'(fcl_pkg::mul_q15(ia, r.sn)));
        end
        // Target selection by mode; position picks step count or i_pos_target
        n.id_t = i_id_target;
        n.iq_t = i_cascade_iq;
        n.align_id = fcl_pkg::ZERO16;
        case (r.mode)
          fcl_pkg::FCL_TORQUE: n.iq_t = i_torque_target;
          fcl_pkg::FCL_VELOCITY: n.vel_t = i_vel_target;
          fcl_pkg::FCL_POSITION: begin
            n.pos_t = i_step_dir_en ? r.step_pos : i_pos_target;
          end
          fcl_pkg::FCL_ALIGN: begin
            // Slow D-axis current ramp toward the alignment current
            n.align_id = fcl_pkg::sat16(40'(r.align_id) + 40'(fcl_pkg::ALIGN_STEP));
            if (n.align_id > i_align_current) n.align_id = i_align_current;
            n.id_t = n.align_id;
            n.iq_t = fcl_pkg::ZERO16;
          end
          fcl_pkg::FCL_PWM_TORQ, fcl_pkg::FCL_ANA_TORQ: begin
            n.iq_t = r.ref_ok ? r.ref_val : fcl_pkg::ZERO16;
          end
          fcl_pkg::FCL_PWM_VEL, fcl_pkg::FCL_ANA_VEL: begin
            n.vel_t = r.ref_ok ? r.ref_val : fcl_pkg::ZERO16;
          end
          fcl_pkg::FCL_PWM_POS, fcl_pkg::FCL_ANA_POS: begin
            if (r.ref_ok) n.pos_t = {{16{r.ref_val[15]}}, r.ref_val}; // Else hold
          end
          default: begin
            n.id_t = fcl_pkg::ZERO16;
            n.iq_t = fcl_pkg::ZERO16;
          end
        endcase
        n.st = S_REG;
      end
      S_REG: n.st = S_OUT;
      S_OUT: begin
        // Voltage source: external, stopped or regulated
        if (r.mode == fcl_pkg::FCL_OPEN_LOOP) begin
          ud = i_ud_ext;
          uq = i_uq_ext;
        end else if (!pi_hold) begin
          ud = flux_u;
          uq = torq_u;
        end
        n.ud = ud;
        n.uq = uq;
        ua = fcl_pkg::sat16(40'(fcl_pkg::mul_q15(ud, r.cs)) -
                            40'(fcl_pkg::mul_q15(uq, r.sn)));
        ub = fcl_pkg::sat16(40'(fcl_pkg::mul_q15(ud, r.sn)) +
                            40'(fcl_pkg::mul_q15(uq, r.cs)));
        case (r.motor)
          fcl_pkg::FCL_THREE_PHASE: begin
            n.u_a = ua;
            n.u_b = fcl_pkg::sat16(40'(fcl_pkg::mul_q15(ub, fcl_pkg::SQRT3_HALF)) -
                                   40'(ua >>> 1));
            n.u_c = fcl_pkg::sat16(-40'(fcl_pkg::mul_q15(ub, fcl_pkg::SQRT3_HALF)) -
                                   40'(ua >>> 1));
            n.bridge = fcl_pkg::BRIDGE_ALL;
          end
          fcl_pkg::FCL_TWO_PHASE: begin
            n.u_a = ua;
            n.u_b = ub;
            n.u_c = fcl_pkg::ZERO16;
            n.bridge = fcl_pkg::BRIDGE_XY;
          end
          default: begin
            n.u_a = uq; // First bridge only
            n.u_b = fcl_pkg::ZERO16;
            n.u_c = fcl_pkg::ZERO16;
            n.bridge = fcl_pkg::BRIDGE_FIRST;
          end
        endcase
        n.update = 1'b1;
        n.st = S_IDLE;
      end
      default: n.st = S_IDLE;
    endcase
    n.align_on = (n.mode == fcl_pkg::FCL_ALIGN); // Registered mode flag
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_u_a = r.u_a;
  assign o_u_b = r.u_b;
  assign o_u_c = r.u_c;
  assign o_bridge_en = r.bridge;
  assign o_update = r.update;
  assign o_id = r.id;
  assign o_iq = r.iq;
  assign o_vel_target = r.vel_t;
  assign o_pos_target = r.pos_t;
  assign o_ref_value = r.ref_val;
  assign o_ref_valid = r.ref_ok;
  assign o_ref_freq_err = r.freq_err;
  assign o_ref_period = r.per_lat;
  assign o_align_active = r.align_on;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  a_mode_latch: assert property (r.st == S_IDLE && tick |=>
    4'(r.mode) == $past(i_motion_mode) && r.st == S_MEAS)
    else $error("mode not taken at evaluation start");
  a_loop_order: assert property (r.st == S_MEAS |=>
    r.st == S_REG ##1 r.st == S_OUT ##1 (r.update && r.st == S_IDLE))
    else $error("loop stages out of order");
  a_dc_bridge: assert property (r.update && r.motor == fcl_pkg::FCL_DC_MOTOR |->
    r.u_b == 16'sh0000 && r.u_c == 16'sh0000 && r.bridge == 3'h1)
    else $error("DC motor drives beyond the first bridge");
  a_two_phase_out: assert property (r.update && r.motor == fcl_pkg::FCL_TWO_PHASE |->
    r.u_c == 16'sh0000 && r.bridge == 3'h3)
    else $error("two-phase output uses the third phase");
  a_open_loop_pass: assert property (r.st == S_OUT && r.mode == fcl_pkg::FCL_OPEN_LOOP |=>
    r.ud == $past(i_ud_ext) && r.uq == $past(i_uq_ext))
    else $error("open-loop voltages not passed through");
  a_torque_pass: assert property (r.st == S_MEAS && r.mode == fcl_pkg::FCL_TORQUE |=>
    r.iq_t == $past(i_torque_target))
    else $error("torque target not forwarded");
  a_ref_zero: assert property (r.st == S_MEAS && !r.ref_ok &&
    r.mode inside {fcl_pkg::FCL_PWM_TORQ, fcl_pkg::FCL_ANA_TORQ} |=> r.iq_t == 16'sh0000)
    else $error("invalid reference did not zero the torque target");
  a_pos_hold: assert property (r.st == S_MEAS && !r.ref_ok &&
    r.mode inside {fcl_pkg::FCL_PWM_POS, fcl_pkg::FCL_ANA_POS} |=> $stable(r.pos_t))
    else $error("invalid reference moved the position target");
  a_freq_reject: assert property (i_pwm_check_en && r.per_lat < PWM_MIN &&
    r.mode inside {fcl_pkg::FCL_PWM_TORQ, fcl_pkg::FCL_PWM_VEL, fcl_pkg::FCL_PWM_POS} |=> !r.ref_ok)
    else $error("out-of-range PWM reference accepted");
  a_step_count: assert property (step_rise && i_step_dir_en |=>
    r.step_pos == ($past(r.dir_l) ? $past(r.step_pos) - 1 : $past(r.step_pos) + 1))
    else $error("step count off");
  a_align_angle: assert property (r.st == S_MEAS && r.mode == fcl_pkg::FCL_ALIGN |->
    r.sn == 16'sh0000 && r.cs == 16'sh7FFF)
    else $error("alignment angle not fixed");

  c_three_phase: cover property (r.update && r.motor == fcl_pkg::FCL_THREE_PHASE);
  c_open_loop: cover property (r.update && r.mode == fcl_pkg::FCL_OPEN_LOOP);
  c_step_edge: cover property (step_rise && i_step_dir_en);
  c_ref_valid: cover property (r.ref_ok && r.mode == fcl_pkg::FCL_PWM_TORQ);

endmodule // fcl_current_loop

// *** test/fcl_pwm_src.sv ***
// Far-side model: a PWM reference source with a set period and high time.
// Assumes one clock; the pin idles low while the high time is zero.
`timescale 1ns/1ps
module fcl_pwm_src (
  input wire logic i_ref_clk,
  input wire logic [9:0] i_period,
  input wire logic [9:0] i_high,
  output logic o_pin
);
  logic [9:0] cnt_r = 10'h000;
  initial o_pin = 1'b0;
  // Counter wraps at the period, pin is high for the first i_high clocks
  always @(posedge i_ref_clk) begin
    cnt_r <= (cnt_r + 10'h001 >= i_period) ? 10'h000 : cnt_r + 10'h001;
    o_pin <= (cnt_r < i_high);
  end
endmodule // fcl_pwm_src

// *** test/fcl_current_loop_tb.sv ***
// Bench for the current loop: voltage, transform, regulator, target and pin paths.
// Assumes a short loop divider and a narrow PWM window set below.
`timescale 1ns/1ps
module fcl_current_loop_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mt = '0;
  logic [3:0] mm = '0;
  logic signed [15:0] cu = '0, cv = '0, cw = '0, ang = '0, idt = '0, tqt = '0, ciq = '0;
  logic signed [15:0] vt = '0, kpf = '0, kif = '0, kpt = '0, kit = '0, lim = '0, udx = '0;
  logic signed [15:0] uqx = '0, alc = '0, ana = '0, ofs = '0, gn = '0;
  logic signed [31:0] pt = 32'sh0000_0123;
  logic sde = '0, stp = '0, dir = '0, cke = '0, anv = '0, pin;
  logic [9:0] per = '0, hi = '0;
  logic signed [15:0] ua, ub, uc, id, iq, vo, rv;
  logic signed [31:0] po;
  logic [2:0] br;
  logic [19:0] rper;
  logic upd, rok, rerr, aln;
  int fail_count = 0, tests_run = 0;
  fcl_current_loop #(.LOOP_DIV(20'h8), .PWM_MIN(20'h14), .PWM_MAX(20'hC8)) fcl_current_loop_i (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_motor_type(mt), .i_motion_mode(mm),
    .i_cur_u(cu), .i_cur_v(cv), .i_cur_w(cw), .i_angle(ang), .i_id_target(idt),
    .i_torque_target(tqt), .i_cascade_iq(ciq), .i_vel_target(vt), .i_pos_target(pt),
    .i_kp_flux(kpf), .i_ki_flux(kif), .i_kp_torque(kpt), .i_ki_torque(kit),
    .i_u_limit(lim), .i_ud_ext(udx), .i_uq_ext(uqx), .i_align_current(alc),
    .i_step_dir_en(sde), .i_step_pin(stp), .i_dir_pin(dir), .i_pwm_ref_pin(pin),
    .i_pwm_check_en(cke), .i_analog_ref(ana), .i_analog_valid(anv), .i_ref_offset(ofs),
    .i_ref_gain(gn), .o_u_a(ua), .o_u_b(ub), .o_u_c(uc), .o_bridge_en(br),
    .o_update(upd), .o_id(id), .o_iq(iq), .o_vel_target(vo), .o_pos_target(po),
    .o_ref_value(rv), .o_ref_valid(rok), .o_ref_freq_err(rerr), .o_ref_period(rper),
    .o_align_active(aln));
  fcl_pwm_src fcl_pwm_src_i (.i_ref_clk(clk), .i_period(per), .i_high(hi), .o_pin(pin));
  initial forever #5 clk = ~clk;
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic go();
    @(posedge clk);
    #1;
  endtask
  // Wait for n update pulses, bounded
  task automatic loops(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      #2;
      while (upd !== 1'b1 && k < 100) begin
        @(posedge clk);
        #2;
        k++;
      end
      if (k >= 100) begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask
  task automatic chk(input string nm, input logic signed [31:0] e, g, input int tol);
    tests_run++;
    if ((^g === 1'bx) || (g - e > tol) || (e - g > tol)) begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic t_open(input logic [1:0] m, input logic signed [31:0] ea, eb, ec, ebr);
    go();
    mt = m; mm = 4'h4; udx = 16'sh2000; uqx = 16'sh1000;
    loops(2);
    chk("u_a", ea, ua, 8);
    chk("u_b", eb, ub, 8);
    chk("u_c", ec, uc, 8);
    chk("bridge", ebr, {29'h0, br}, 0);
  endtask
  task automatic t_park();
    go();
    mt = 2'h0; mm = 4'h1; cu = 16'sh1000; cv = 16'sh1000; cw = -16'sh1000;
    loops(2);
    chk("id", 32'sh1000, id, 8);
    chk("iq", 32'sh1279, iq, 8);
    go(); ang = 16'sh4000; loops(2);
    chk("id", 32'sh1279, id, 8);
    chk("iq", -32'sh1000, iq, 8);
    go(); mt = 2'h2; loops(2);
    chk("iq", 32'sh1000, iq, 0);
  endtask
  task automatic t_pi();
    go();
    mt = 2'h1; ang = '0; cu = '0; cv = '0; cw = '0; idt = 16'sh0200; tqt = 16'sh0400;
    kpf = 16'sh0100; kpt = 16'sh0100; lim = 16'sh7FFF;
    loops(2);
    chk("u_a", 32'sh0200, ua, 8);
    chk("u_b", 32'sh0400, ub, 8);
    go(); lim = 16'sh0100; loops(2);
    chk("u_b", 32'sh0100, ub, 8);
    go(); mm = 4'hC; loops(1);
    chk("u_b", 32'sh0, ub, 0);
    go(); mm = 4'h1; kpt = '0; kit = 16'sh4000; lim = 16'sh7FFF; loops(1);
    chk("u_b", 32'sh0200, ub, 8);
    loops(1);
    chk("u_b", 32'sh0400, ub, 8);
    go(); mm = 4'h0; kit = '0; kpt = 16'sh0100; loops(1);
    chk("u_b", 32'sh0, ub, 0);
  endtask
  task automatic t_tgt();
    go(); mm = 4'h2; vt = 16'sh0321; loops(2);
    chk("vel", 32'sh0321, vo, 0);
    go(); mm = 4'h3; loops(2);
    chk("pos", pt, po, 0);
    go(); sde = 1'b1;
    for (int k = 0; k < 4; k++) begin
      go(); dir = (k == 3);
      repeat (5) go();
      stp = 1'b1;
      repeat (5) go();
      stp = 1'b0;
    end
    loops(2);
    chk("pos", 32'sh2, po, 0);
    go(); mm = 4'h5; loops(2);
    chk("align", 32'sh1, {31'h0, aln}, 0);
  endtask
  task automatic t_pin();
    go(); mm = 4'h7; cke = 1'b1; per = 10'h064; hi = 10'h04B; gn = 16'sh0100;
    repeat (300) go();
    loops(2);
    chk("period", 32'sh64, {12'h0, rper}, 0);
    chk("valid", 32'sh1, {31'h0, rok}, 0);
    chk("vel", 32'sh19, vo, 0);
    go(); ofs = 16'sh0005; gn = 16'sh0200; loops(2);
    chk("vel", 32'sh28, vo, 0);
    chk("ref", 32'sh28, rv, 0);
    go(); mm = 4'h8; loops(2);
    chk("pos", 32'sh28, po, 0);
    go(); mm = 4'h6; loops(2);
    chk("u_b", 32'sh28, ub, 8);
    go(); per = 10'h010; hi = 10'h008; repeat (100) go(); loops(2);
    chk("freq_err", 32'sh1, {31'h0, rerr}, 0);
    chk("u_b", 32'sh0, ub, 0);
    go(); mm = 4'h8; loops(2);
    chk("pos", 32'sh28, po, 0);
    go(); mm = 4'h7; loops(2);
    chk("vel", 32'sh0, vo, 0);
    go(); mm = 4'hA; anv = 1'b1; ana = 16'sh0045; loops(2);
    chk("vel", 32'sh80, vo, 0);
  endtask
  initial begin
    repeat (16) go();
    rst = 1'b0;
    go();
    chk("bridge", 32'sh0, {29'h0, br}, 0);
    chk("update", 32'sh0, {31'h0, upd}, 0);
    t_open(2'h0, 32'sh2000, -32'sh0225, -32'sh1DDB, 32'sh7);
    t_open(2'h1, 32'sh2000, 32'sh1000, 32'sh0, 32'sh3);
    t_open(2'h2, 32'sh1000, 32'sh0, 32'sh0, 32'sh1);
    t_park();
    t_pi();
    t_tgt();
    t_pin();
    tally_and_finish();
  end
endmodule // fcl_current_loop_tb
